/* File: deec_device.sv */
// deec_device: data eeprom array with row latches and timed erase-then-program cycle
// Operation
// - read mode returns array byte next cycle
// - cpu never executes code from eeprom
// - host reads cell twice, drops first
// - write mode captures writes into sixteen latches
// - start programs latches into last-written row
// - host keeps one row between programmings
// - end clears start and mode, raises irq
// - vector fetch withdraws the interrupt request
// - latches cleared at end/mode fall; rewrite ANDs
// - latch contents are never readable
// - wait entered now, or after cycle ends
// - halt aborts programming at once
// - read in write mode leaves bus undriven
// - write in read mode is not latched
// - interrupted cycle leaves cells undefined
// - mode clear ignored while programming
// - csr resets zero, bits 7:3 read zero
// - internal timing, erase chained before program
// - csr sits at address 002c
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module deec_device #(
    parameter int ERASE_LEN = deec_pkg::ERASE_CYCLES,
    parameter int PROG_LEN  = deec_pkg::PROG_CYCLES,
    parameter int DEPTH     = 256
) (
    input  wire logic clk,
    input  wire logic resetn,
    deec_if.dev       bus
);
    import deec_pkg::*;

    localparam int CNT_W = 16;

    typedef struct packed {
        logic                       ie;
        logic                       lat;
        logic                       program_start_busy_bit;
        deec_phase_t                phase;
        logic [CNT_W-1:0]           cnt;
        logic [LATCH_N-1:0]         lvalid;
        logic [LATCH_N*DATA_W-1:0]  ldata;
        logic [ADDR_W-ROW_LSB-1:0]  row;
        logic                       wait_pend;
        logic                       in_wait;
        logic                       irq;
        logic [7:0]                 rdata;
        logic                       rdata_oe;
    } deec_state_t;

    deec_state_t state_ff;
    deec_state_t nxt_state;
    logic [7:0]  mem [DEPTH];

    // address lies inside the eeprom window
    function automatic logic in_ee(input logic [15:0] a);
        in_ee = (a >= EE_BASE) && (a < 16'(EE_BASE + EE_SIZE));
    endfunction : in_ee

    // address hits the control/status register
    function automatic logic is_csr(input logic [15:0] a);
        is_csr = (a == CSR_ADDR);
    endfunction : is_csr

    // one byte lane of the packed latch bank
    function automatic logic [7:0] latch_byte(input logic [LATCH_N*DATA_W-1:0] d, input int idx);
        latch_byte = d[idx*DATA_W +: DATA_W];
    endfunction : latch_byte

    logic [15:0] ee_off;
    logic [3:0]  lsel;
    logic        prog_done;
    assign ee_off    = 16'(bus.addr - EE_BASE);
    assign lsel      = bus.addr[ROW_LSB-1:0];
    assign prog_done = (state_ff.phase == DEEC_PROG) && (state_ff.cnt == 16'(PROG_LEN - 1));

    // next-state logic for control register, latches and cycle sequencer
    // order of the blocks below matters: later assignments win
    // - a vector fetch clears the request first, so a completion in
    //   the same cycle still raises it again (set wins)
    // - the sequencer runs after the register write, so a software
    //   abort and a natural end cannot both be lost
    // - halt comes last so that it overrides the phase and busy bit set by any block above
    // trade-off: one wide struct keeps the code short, at the cost
    // of a large register that synthesis must keep apart
    always_comb begin
        nxt_state          = state_ff;
        nxt_state.rdata_oe = 1'b0;
        nxt_state.rdata    = 8'h00;
        if (bus.vec_fetch)
            nxt_state.irq = 1'b0;
        // register read; latch contents have no read path
        if (bus.rd && is_csr(bus.addr)) begin
            nxt_state.rdata    = {5'b0, state_ff.ie, state_ff.lat, state_ff.program_start_busy_bit};
            nxt_state.rdata_oe = 1'b1;
        end else if (bus.rd && in_ee(bus.addr) && !state_ff.lat && !state_ff.in_wait) begin
            nxt_state.rdata    = mem[ee_off[7:0]];
            nxt_state.rdata_oe = 1'b1;                                  // lat=1 leaves it low
        end
        // register write; the mode bit may only fall while idle
        if (bus.wr && is_csr(bus.addr)) begin
            nxt_state.ie = bus.wdata[CSR_IE_BIT];
            if (bus.wdata[CSR_LAT_BIT])
                nxt_state.lat = 1'b1;
            else if (!state_ff.program_start_busy_bit) begin
                nxt_state.lat = 1'b0;
                if (state_ff.lat)
                    nxt_state.lvalid = '0;                              // mode falling edge
            end
            if (bus.wdata[CSR_PGM_BIT] && (state_ff.lat || bus.wdata[CSR_LAT_BIT]) && !state_ff.program_start_busy_bit) begin
                nxt_state.program_start_busy_bit   = 1'b1;
                nxt_state.phase = DEEC_ERASE;
                nxt_state.cnt   = '0;
            end else if (!bus.wdata[CSR_PGM_BIT] && state_ff.program_start_busy_bit) begin
                nxt_state.program_start_busy_bit   = 1'b0;                                 // abort: cells undefined
                nxt_state.phase = DEEC_IDLE;
            end
        end
        // latch capture only in write mode before start
        if (bus.wr && in_ee(bus.addr) && state_ff.lat && !state_ff.program_start_busy_bit) begin
            for (int i = 0; i < LATCH_N; i++) begin
                if (4'(i) == lsel) begin
                    nxt_state.ldata[i*DATA_W +: DATA_W] = state_ff.lvalid[i] ?
                        (latch_byte(state_ff.ldata, i) & bus.wdata) : bus.wdata;
                    nxt_state.lvalid[i] = 1'b1;
                end
            end
            nxt_state.row = ee_off[ADDR_W-1:ROW_LSB];
        end
        // timed erase then program
        case (state_ff.phase)
            DEEC_IDLE: ;
            DEEC_ERASE: begin
                nxt_state.cnt = state_ff.cnt + 16'd1;
                if (state_ff.cnt == 16'(ERASE_LEN - 1)) begin
                    nxt_state.phase = DEEC_PROG;
                    nxt_state.cnt   = '0;
                end
            end
            DEEC_PROG: begin
                nxt_state.cnt = state_ff.cnt + 16'd1;
                if (prog_done) begin
                    nxt_state.phase  = DEEC_IDLE;
                    nxt_state.program_start_busy_bit    = 1'b0;
                    nxt_state.lat    = 1'b0;
                    nxt_state.lvalid = '0;
                    if (state_ff.ie)
                        nxt_state.irq = 1'b1;                           // set wins over vector fetch
                end
            end
            default: nxt_state.phase = DEEC_IDLE;
        endcase
        // wait waits for cycle end
        // a request seen while busy is parked in wait_pend and taken
        // in the cycle the sequencer goes idle; any bus access wakes
        // the array again; a waking eeprom read is not served, a waking csr access or write is
        if (bus.wait_for_interrupt_instr)
            nxt_state.wait_pend = 1'b1;
        if (nxt_state.wait_pend && nxt_state.phase == DEEC_IDLE) begin
            nxt_state.in_wait   = 1'b1;
            nxt_state.wait_pend = 1'b0;
        end
        if (bus.irq || bus.rd || bus.wr)
            nxt_state.in_wait = nxt_state.in_wait && !(bus.rd || bus.wr);
        // halt stops the erase/program cycle at once
        // limitation: the write mode bit and latches survive, so the
        // row being written is left undefined and must be rewritten
        if (bus.halt) begin
            nxt_state.phase = DEEC_IDLE;
            nxt_state.program_start_busy_bit   = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff     <= '0;
            state_ff.ie  <= CSR_RESET[CSR_IE_BIT];
        end else begin
            state_ff <= nxt_state;
        end
    end

    // array: cells of the target row written at the last program cycle; no reset on purpose
    // the cells are nonvolatile in the real part, so a reset must not
    // touch them; only bytes that were latched since the last cycle
    // are written, the rest of the row keeps its old contents
    always_ff @(posedge clk) begin
        if (prog_done && !bus.halt) begin
            for (int i = 0; i < LATCH_N; i++) begin
                if (state_ff.lvalid[i])
                    mem[{state_ff.row[3:0], 4'(i)}] <= latch_byte(state_ff.ldata, i);
            end
        end
    end

    // bus outputs come straight from the state register
    assign bus.rdata    = state_ff.rdata;
    assign bus.rdata_oe = state_ff.rdata_oe;
    assign bus.irq      = state_ff.irq;
    assign bus.in_wait  = state_ff.in_wait;
endmodule : deec_device

/* File: deec_pkg.sv */
// deec_pkg: shared constants and types for the data eeprom controller and its cpu-side bus end
package deec_pkg;
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 8;
    localparam int          LATCH_N       = 16;
    localparam int          ROW_LSB       = 4;
    localparam logic [15:0] CSR_ADDR      = 16'h002c;
    localparam logic [15:0] EE_BASE       = 16'hc000;
    localparam logic [15:0] EE_SIZE       = 16'h0100;
    localparam logic [7:0]  CSR_RESET     = 8'h00;
    localparam int          CSR_IE_BIT    = 2;
    localparam int          CSR_LAT_BIT   = 1;
    localparam int          CSR_PGM_BIT   = 0;
    localparam int          ERASE_CYCLES  = 1000;
    localparam int          PROG_CYCLES   = 1000;
    localparam logic [15:0] HOST_EE_ADDR  = 16'hc000;
    localparam logic [7:0]  HOST_RD_CSR   = 8'h00;
    localparam logic [7:0]  HOST_WR_CSR   = 8'h01;
    localparam logic [7:0]  HOST_RD_EE    = 8'h02;
    localparam logic [7:0]  HOST_WR_EE    = 8'h03;
    localparam logic [7:0]  HOST_STATUS   = 8'h04;
    localparam logic [7:0]  HOST_ADDR_REG = 8'h05;
    localparam logic [7:0]  HOST_DATA_REG = 8'h06;

    typedef enum logic [1:0] {DEEC_IDLE, DEEC_ERASE, DEEC_PROG} deec_phase_t;
endpackage : deec_pkg

/* File: deec_if.sv */
// deec_if: memory bus between cpu end and the data eeprom controller
`timescale 1ns/10ps
interface deec_if;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        fetch;
    logic        vec_fetch;
    logic        wait_for_interrupt_instr;
    logic        halt;
    logic [7:0]  rdata;
    logic        rdata_oe;
    logic        irq;
    logic        in_wait;

    modport dev (input addr, wdata, wr, rd, fetch, vec_fetch, wait_for_interrupt_instr, halt,
                 output rdata, rdata_oe, irq, in_wait);
    modport cpu (output addr, wdata, wr, rd, fetch, vec_fetch, wait_for_interrupt_instr, halt,
                 input rdata, rdata_oe, irq, in_wait);
endinterface : deec_if

/* File: deec_cpu.sv */
// deec_cpu: cpu-side bus end driving the eeprom controller from a simple command port
`timescale 1ns/10ps
module deec_cpu (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [7:0]  sw_rdata,
    input  wire logic        cpu_wfi,
    input  wire logic        cpu_halt,
    deec_if.cpu              bus
);
    import deec_pkg::*;

    typedef enum logic [1:0] {DEEC_C_IDLE, DEEC_C_RD1, DEEC_C_RD2, DEEC_C_RD3} deec_cstate_t;

    typedef struct packed {
        deec_cstate_t st;
        logic [15:0]  addr;
        logic [7:0]   wdata;
        logic         wr;
        logic         rd;
        logic         vec_fetch;
        logic         wait_for_interrupt_instr;
        logic         halt;
        logic [15:0]  ee_addr;
        logic [7:0]   last;
        logic         irq_seen;
        logic [7:0]   rdata;
    } deec_cpu_state_t;

    deec_cpu_state_t c_ff;
    deec_cpu_state_t nxt_c;

    // bus issue; eeprom reads go out twice back to back, first result dropped
    always_comb begin
        nxt_c           = c_ff;
        nxt_c.wr        = 1'b0;
        nxt_c.rd        = 1'b0;
        nxt_c.vec_fetch = 1'b0;
        nxt_c.wait_for_interrupt_instr       = cpu_wfi;
        nxt_c.halt      = cpu_halt;
        nxt_c.rdata     = 8'h00;
        // vector fetch once the interrupt is seen clears it
        if (bus.irq && !c_ff.vec_fetch) begin
            nxt_c.vec_fetch = 1'b1;
            nxt_c.irq_seen  = 1'b1;
        end
        case (c_ff.st)
            DEEC_C_IDLE: begin
                if (sw_wr && sw_addr == HOST_ADDR_REG) nxt_c.ee_addr = {8'hc0, sw_wdata};
                if (sw_wr && sw_addr == HOST_WR_CSR) begin
                    nxt_c.addr = CSR_ADDR; nxt_c.wdata = sw_wdata; nxt_c.wr = 1'b1;
                end
                if (sw_wr && sw_addr == HOST_WR_EE) begin           // one row only
                    nxt_c.addr = c_ff.ee_addr; nxt_c.wdata = sw_wdata; nxt_c.wr = 1'b1;
                end
                if (sw_rd && sw_addr == HOST_RD_CSR) begin
                    nxt_c.addr = CSR_ADDR; nxt_c.rd = 1'b1; nxt_c.st = DEEC_C_RD2;
                end
                if (sw_rd && sw_addr == HOST_RD_EE) begin
                    nxt_c.addr = c_ff.ee_addr; nxt_c.rd = 1'b1; nxt_c.st = DEEC_C_RD1;
                end
                if (sw_rd && sw_addr == HOST_DATA_REG) nxt_c.rdata = c_ff.last;
                if (sw_rd && sw_addr == HOST_STATUS) begin
                    nxt_c.rdata    = {7'b0, c_ff.irq_seen};
                    nxt_c.irq_seen = 1'b0;
                end
            end
            DEEC_C_RD1: begin
                nxt_c.rd = 1'b1; nxt_c.st = DEEC_C_RD2;
            end
            DEEC_C_RD2: begin
                nxt_c.st = DEEC_C_RD3;                              // answer to the first strobe is not kept
            end
            DEEC_C_RD3: begin
                nxt_c.last = bus.rdata_oe ? bus.rdata : 8'hff;      // second answer kept
                nxt_c.st   = DEEC_C_IDLE;
            end
            default: nxt_c.st = DEEC_C_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) c_ff <= '0;
        else         c_ff <= nxt_c;
    end

    assign bus.addr      = c_ff.addr;
    assign bus.wdata     = c_ff.wdata;
    assign bus.wr        = c_ff.wr;
    assign bus.rd        = c_ff.rd;
    assign bus.fetch     = 1'b0;                                    // no code fetch from eeprom
    assign bus.vec_fetch = c_ff.vec_fetch;
    assign bus.wait_for_interrupt_instr       = c_ff.wait_for_interrupt_instr;
    assign bus.halt      = c_ff.halt;
    assign sw_rdata      = c_ff.rdata;
endmodule : deec_cpu

/* File: deec_assertions.sv */
// deec_assertions: bus-level checks between cpu end and eeprom controller
`timescale 1ns/10ps
module deec_assertions #(
    parameter int ERASE_LEN = 4,
    parameter int PROG_LEN  = 4
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic        vec_fetch,
    input wire logic        wait_for_interrupt_instr,
    input wire logic [7:0]  rdata,
    input wire logic        rdata_oe,
    input wire logic        irq,
    input wire logic        in_wait
);
    import deec_pkg::*;
    typedef struct packed {
        logic        lat;
        logic        busy;
        logic [11:0] cnt;
    } deec_chk_t;
    deec_chk_t st_ff;
    deec_chk_t nxt_st;
    logic      csr_wr;
    logic      ee_acc;
    assign csr_wr = wr && addr == CSR_ADDR;
    assign ee_acc = addr >= EE_BASE && addr < EE_BASE + EE_SIZE;
    // shadow of mode and busy; busy is only known for cycles that end in an irq
    always_comb begin
        nxt_st = st_ff;
        if (st_ff.busy) nxt_st.cnt = st_ff.cnt + 12'h001;
        if (csr_wr && (wdata[1] || !st_ff.busy)) nxt_st.lat = wdata[1];
        if (csr_wr && wdata[0] && wdata[2] && !st_ff.busy) begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt  = 12'h000;
        end
        if (st_ff.busy && irq) begin
            nxt_st.busy = 1'b0;
            nxt_st.lat  = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) st_ff <= '0;
        else st_ff <= nxt_st;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_csr_rd;
        rd && addr == CSR_ADDR && !in_wait;
    endsequence
    sequence s_ee_rd;
        rd && ee_acc && !in_wait;
    endsequence
    chk_oe_after_rd: assert property (rdata_oe |-> $past(rd))
        else $error("read data driven without a read");
    chk_csr_rsvd_zero: assert property (s_csr_rd |=> rdata_oe && rdata[7:3] == 5'h00)
        else $error("csr read bad");
    chk_ee_rd_data: assert property (s_ee_rd ##0 !st_ff.lat |=> rdata_oe)
        else $error("eeprom read not driven");
    chk_ee_rd_float: assert property (rd && ee_acc && st_ff.lat |=> !rdata_oe)
        else $error("eeprom read driven in write mode");
    chk_irq_cause: assert property ($rose(irq) |-> st_ff.busy && st_ff.cnt >= ERASE_LEN + PROG_LEN - 1)
        else $error("irq without full cycle");
    chk_cycle_bound: assert property (st_ff.busy |-> st_ff.cnt <= ERASE_LEN + PROG_LEN + 3)
        else $error("cycle overran");
    chk_irq_hold: assert property (irq && !vec_fetch |=> irq)
        else $error("irq dropped early");
    chk_irq_vec_clear: assert property ($fell(irq) |-> $past(vec_fetch))
        else $error("irq fell without vector fetch");
    chk_wait_idle: assert property (wait_for_interrupt_instr && !st_ff.busy |-> ##[1:2] in_wait)
        else $error("wait not entered");
    chk_wait_defer: assert property (st_ff.busy && !irq |-> !in_wait)
        else $error("wait entered while busy");
endmodule : deec_assertions

/* File: tb.sv */
// tb: drives the cpu command port and checks the eeprom controller
`timescale 1ns/10ps
module tb;
    import deec_pkg::*;
    localparam int LEN = 24; // short cycle lengths keep the run brief
    logic       clk      = 1'b0;
    logic       resetn   = 1'b0;
    logic [7:0] sw_addr  = 8'h00;
    logic [7:0] sw_wdata = 8'h00;
    logic       sw_wr    = 1'b0;
    logic       sw_rd    = 1'b0;
    logic [7:0] sw_rdata;
    logic       cpu_wfi  = 1'b0;
    logic       cpu_halt = 1'b0;
    logic       rd_q     = 1'b0;
    logic [7:0] last_d;
    logic       last_oe;
    logic [7:0] sw_seen;
    int         rd_cnt   = 0;
    int         n;
    int         num_errors  = 0;
    int         comparisons = 0;
    deec_if bus_if ();
    deec_device #(.ERASE_LEN(LEN), .PROG_LEN(LEN)) deec_device_i (.clk(clk), .resetn(resetn), .bus(bus_if));
    deec_cpu deec_cpu_i (.clk(clk), .resetn(resetn), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata), .cpu_wfi(cpu_wfi), .cpu_halt(cpu_halt), .bus(bus_if));
    deec_assertions #(.ERASE_LEN(LEN), .PROG_LEN(LEN)) deec_assertions_i (.clk(clk), .resetn(resetn),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .vec_fetch(bus_if.vec_fetch),
        .wait_for_interrupt_instr(bus_if.wait_for_interrupt_instr), .rdata(bus_if.rdata), .rdata_oe(bus_if.rdata_oe), .irq(bus_if.irq),
        .in_wait(bus_if.in_wait));
    always #5 clk = ~clk;
    // keep the answer to the latest bus read; a double read leaves the second
    always @(posedge clk) begin
        rd_q <= bus_if.rd;
        if (bus_if.rd) rd_cnt <= rd_cnt + 1;
        if (rd_q) begin
            last_d  <= bus_if.rdata;
            last_oe <= bus_if.rdata_oe;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_cmd(input logic [7:0] code, input logic [7:0] data);
        @(posedge clk);
        sw_addr  <= code;
        sw_wdata <= data;
        sw_wr    <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : wr_cmd
    // command port data stand only in the cycle after the strobe
    task automatic rd_cmd(input logic [7:0] code);
        @(posedge clk);
        sw_addr <= code;
        sw_rd   <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        @(negedge clk);
        sw_seen = sw_rdata;
        repeat (6) @(posedge clk);
    endtask : rd_cmd
    task automatic ee_wr(input logic [7:0] lo, input logic [7:0] data);
        wr_cmd(HOST_ADDR_REG, lo);
        wr_cmd(HOST_WR_EE, data);
    endtask : ee_wr
    task automatic ee_rd(input logic [7:0] lo);
        wr_cmd(HOST_ADDR_REG, lo);
        rd_cmd(HOST_RD_EE);
    endtask : ee_rd
    task automatic results;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd_cmd(HOST_RD_CSR);
        check(last_d, CSR_RESET);
        wr_cmd(HOST_WR_CSR, 8'hfc);
        rd_cmd(HOST_RD_CSR);
        check(last_d, 8'h04);
        wr_cmd(HOST_WR_CSR, 8'h06);
        ee_wr(8'h13, 8'hf0);
        ee_wr(8'h13, 8'h3c);
        ee_wr(8'h1f, 8'ha5);
        ee_rd(8'h1f);
        check({7'h00, last_oe}, 8'h00);
        wr_cmd(HOST_WR_CSR, 8'h07);
        rd_cmd(HOST_RD_CSR);
        check(last_d, 8'h07);
        wr_cmd(HOST_WR_CSR, 8'h05);
        rd_cmd(HOST_RD_CSR);
        check(last_d, 8'h07);
        @(posedge clk) cpu_wfi <= 1'b1;
        @(posedge clk) cpu_wfi <= 1'b0;
        repeat (3) @(posedge clk);
        check({7'h00, bus_if.in_wait}, 8'h00);
        // sample on the falling edge, clear of the edge that launches irq
        for (n = 0; n < 80 && bus_if.irq !== 1'b1; n++) @(negedge clk);
        check({7'h00, bus_if.irq}, 8'h01);
        repeat (3) @(posedge clk);
        check({7'h00, bus_if.in_wait}, 8'h01);
        // first read wakes the array and is not served; the kept answer is the second
        ee_rd(8'h13);
        rd_cmd(HOST_DATA_REG);
        check(sw_seen, 8'h30);
        rd_cmd(HOST_RD_CSR);
        check(last_d, 8'h04);
        n = rd_cnt;
        ee_rd(8'h13);
        check(last_d, 8'h30);
        check(8'(rd_cnt - n), 8'h02);
        rd_cmd(HOST_DATA_REG);
        check(sw_seen, 8'h30);
        ee_rd(8'h1f);
        check(last_d, 8'ha5);
        ee_wr(8'h13, 8'h00);
        ee_rd(8'h13);
        check(last_d, 8'h30);
        // halt in mid-cycle: cycle dropped, write mode kept
        wr_cmd(HOST_WR_CSR, 8'h02);
        ee_wr(8'h25, 8'h11);
        wr_cmd(HOST_WR_CSR, 8'h03);
        @(posedge clk) cpu_halt <= 1'b1;
        @(posedge clk) cpu_halt <= 1'b0;
        repeat (60) @(posedge clk);
        rd_cmd(HOST_RD_CSR);
        check(last_d, 8'h02);
        wr_cmd(HOST_WR_CSR, 8'h00);
        rd_cmd(HOST_RD_CSR);
        check(last_d, 8'h00);
        @(posedge clk) cpu_wfi <= 1'b1;
        @(posedge clk) cpu_wfi <= 1'b0;
        repeat (3) @(posedge clk);
        check({7'h00, bus_if.in_wait}, 8'h01);
        results();
    end
endmodule : tb
